// file: design/dsg_pkg.sv
package dsg_pkg;

    // ==========================================================
    // Address map
    // ==========================================================
    localparam logic [31:0] SYS_CTRL_BASE = 32'h400FE000;
    localparam logic [31:0] OFF_RUN_GATES = 32'h00000100;
    localparam logic [31:0] OFF_SLEEP_GATES = 32'h00000110;
    localparam logic [31:0] OFF_DEEP_GATES = 32'h00000120;
    localparam logic [31:0] OFF_RUN_CONFIG = 32'h00000130;
    localparam logic [31:0] OFF_IRQ_STATUS = 32'h00000140;
    localparam logic [31:0] OFF_IRQ_MASK = 32'h00000144;
    localparam logic [31:0] ADDR_RUN_GATES = SYS_CTRL_BASE + OFF_RUN_GATES;
    localparam logic [31:0] ADDR_SLEEP_GATES = SYS_CTRL_BASE + OFF_SLEEP_GATES;
    localparam logic [31:0] ADDR_DEEP_GATES = SYS_CTRL_BASE + OFF_DEEP_GATES;
    localparam logic [31:0] ADDR_RUN_CONFIG = SYS_CTRL_BASE + OFF_RUN_CONFIG;
    localparam logic [31:0] ADDR_IRQ_STATUS = SYS_CTRL_BASE + OFF_IRQ_STATUS;
    localparam logic [31:0] ADDR_IRQ_MASK = SYS_CTRL_BASE + OFF_IRQ_MASK;

    // ==========================================================
    // Field layout and reset values
    // ==========================================================
    localparam int NUM_UNITS = 3;
    localparam int UNIT_WATCHDOG = 0;
    localparam int UNIT_ADC = 1;
    localparam int UNIT_PWM = 2;
    localparam int BIT_WATCHDOG = 3;
    localparam int BIT_ADC = 16;
    localparam int BIT_PWM = 20;
    localparam int BIT_AUTO_GATING = 0;
    localparam int BIT_DEEP_ENTRY = 3;
    localparam logic [31:0] GATE_WRITE_MASK = 32'h00110008;
    localparam logic [31:0] GATE_RESET = 32'h00000000;
    localparam logic [31:0] DEEP_FIXED_ONES = 32'h00000040;
    localparam logic [31:0] DEEP_RESET = 32'h00000040;
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'h00000001;
    localparam logic [31:0] IRQ_FIELD_MASK = 32'h0000000F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DSG_MODE_RUN = 2'b00,
        DSG_MODE_SLEEP = 2'b01,
        DSG_MODE_DEEP = 2'b10
    } dsg_mode_t;

endpackage : dsg_pkg

// file: design/dsg_mode_select.sv
`timescale 1ns/1ps
module dsg_mode_select
    import dsg_pkg::*;
#(
    parameter int UNITS = NUM_UNITS
) (
    input wire logic [UNITS-1:0] run_gates,
    input wire logic [UNITS-1:0] sleep_gates,
    input wire logic [UNITS-1:0] deep_gates,
    input wire logic auto_gating,
    input wire logic [1:0] power_mode,
    output logic [UNITS-1:0] active_gates
);

    // ==========================================================
    // Gate set selection
    // ==========================================================
    // Without auto gating the run set governs every power mode.
    always_comb begin
        active_gates = run_gates;
        if (auto_gating) begin
            case (power_mode)
                DSG_MODE_SLEEP: active_gates = sleep_gates;
                DSG_MODE_DEEP: active_gates = deep_gates;
                default: active_gates = run_gates;
            endcase
        end
    end

endmodule : dsg_mode_select

// file: design/dsg_access_check.sv
`timescale 1ns/1ps
module dsg_access_check
    import dsg_pkg::*;
#(
    parameter int UNITS = NUM_UNITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [UNITS-1:0] clock_enable,
    input wire logic access_valid,
    input wire logic [1:0] access_unit,
    output logic access_done,
    output logic access_fault,
    output logic [UNITS-1:0] fault_hit
);

    // ==========================================================
    // Per-unit access checking
    // ==========================================================
    logic [UNITS-1:0] unit_hit;
    logic [UNITS-1:0] next_fault_hit;
    wire unit_known = (access_unit < 2'(UNITS));

    genvar u;
    generate
        for (u = 0; u < UNITS; u++) begin : g_unit
            assign unit_hit[u] = access_valid && (access_unit == 2'(u));
            assign next_fault_hit[u] = unit_hit[u] && !clock_enable[u];
        end
    endgenerate

    // An unknown unit number is refused as well, so no access ever hangs.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            access_done <= 1'b0;
            access_fault <= 1'b0;
            fault_hit <= '0;
        end else begin
            access_done <= access_valid;
            access_fault <= (|next_fault_hit) || (access_valid && !unit_known);
            fault_hit <= next_fault_hit;
        end
    end

endmodule : dsg_access_check

// file: design/dsg_clock_gating.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module dsg_clock_gating
    import dsg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic [1:0] power_mode,
    output logic [NUM_UNITS-1:0] unit_clock_enable,
    input wire logic unit_access_valid,
    input wire logic [1:0] unit_access_unit,
    output logic unit_access_done,
    output logic unit_access_fault,
    output logic irq
);

    // ==========================================================
    // Write channel
    // ==========================================================
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire aw_take = s_awvalid && s_awready;
    wire w_take = s_wvalid && s_wready;
    wire wr_fire = aw_held && w_held && !s_bvalid;
    wire next_aw_held = (aw_held || aw_take) && !wr_fire;
    wire next_w_held = (w_held || w_take) && !wr_fire;
    wire next_bvalid = wr_fire || (s_bvalid && !s_bready);

    wire wr_run = (aw_addr == ADDR_RUN_GATES);
    wire wr_sleep = (aw_addr == ADDR_SLEEP_GATES);
    wire wr_deep = (aw_addr == ADDR_DEEP_GATES);
    wire wr_config = (aw_addr == ADDR_RUN_CONFIG);
    wire wr_status = (aw_addr == ADDR_IRQ_STATUS);
    wire wr_mask = (aw_addr == ADDR_IRQ_MASK);
    wire wr_mapped = wr_run || wr_sleep || wr_deep || wr_config || wr_status || wr_mask;

    logic [31:0] strb_mask;
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign strb_mask[8*b +: 8] = {8{w_strb[b]}};
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            if (aw_take) begin
                aw_addr <= s_awaddr;
            end
            if (w_take) begin
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
        end
    end

    // Ready is registered, so one address and one data word are held at most.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else begin
            s_awready <= !next_aw_held && !next_bvalid;
            s_wready <= !next_w_held && !next_bvalid;
            s_bvalid <= next_bvalid;
            if (wr_fire) begin
                s_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Gate and configuration registers
    // ==========================================================
    logic [31:0] run_gates;
    logic [31:0] sleep_gates;
    logic [31:0] deep_gates;
    logic [31:0] run_config;

    // Only the bits in write_mask take writes (the three unit bits for the gate registers); other bits keep their reset value of zero.
    function automatic logic [31:0] dsg_merge(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [31:0] lane_mask,
                                              input logic [31:0] write_mask);
        logic [31:0] keep;
        keep = lane_mask & write_mask;
        dsg_merge = (old_value & ~keep) | (new_value & keep);
    endfunction : dsg_merge

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_gates <= GATE_RESET;
            sleep_gates <= GATE_RESET;
            deep_gates <= GATE_RESET;
            run_config <= 32'h00000000;
        end else if (wr_fire) begin
            if (wr_run) begin
                run_gates <= dsg_merge(run_gates, w_data, strb_mask, GATE_WRITE_MASK);
            end
            if (wr_sleep) begin
                sleep_gates <= dsg_merge(sleep_gates, w_data, strb_mask, GATE_WRITE_MASK);
            end
            if (wr_deep) begin
                deep_gates <= dsg_merge(deep_gates, w_data, strb_mask, GATE_WRITE_MASK);
            end
            if (wr_config) begin
                run_config <= dsg_merge(run_config, w_data, strb_mask, CONFIG_WRITE_MASK);
            end
        end
    end

    wire auto_clock_gating_select = run_config[BIT_AUTO_GATING];
    wire [31:0] deep_read = deep_gates | DEEP_FIXED_ONES;

    // ==========================================================
    // Clock enable selection
    // ==========================================================
    logic [NUM_UNITS-1:0] run_units;
    logic [NUM_UNITS-1:0] sleep_units;
    logic [NUM_UNITS-1:0] deep_units;
    logic [NUM_UNITS-1:0] active_gates;

    assign run_units = {run_gates[BIT_PWM], run_gates[BIT_ADC], run_gates[BIT_WATCHDOG]};
    assign sleep_units = {sleep_gates[BIT_PWM], sleep_gates[BIT_ADC], sleep_gates[BIT_WATCHDOG]};
    assign deep_units = {deep_gates[BIT_PWM], deep_gates[BIT_ADC], deep_gates[BIT_WATCHDOG]};

    dsg_mode_select #(
        .UNITS(NUM_UNITS)
    ) u_mode_select (
        .run_gates(run_units),
        .sleep_gates(sleep_units),
        .deep_gates(deep_units),
        .auto_gating(auto_clock_gating_select),
        .power_mode(power_mode),
        .active_gates(active_gates)
    );

    // The enable is a registered level; the clock gate cell itself sits
    // beside each unit and must latch it on the low phase to avoid glitches.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            unit_clock_enable <= '0;
        end else begin
            unit_clock_enable <= active_gates;
        end
    end

    // ==========================================================
    // Unit access fault checking
    // ==========================================================
    logic [NUM_UNITS-1:0] fault_hit;

    dsg_access_check #(
        .UNITS(NUM_UNITS)
    ) u_access_check (
        .clk(clk),
        .reset(reset),
        .clock_enable(unit_clock_enable),
        .access_valid(unit_access_valid),
        .access_unit(unit_access_unit),
        .access_done(unit_access_done),
        .access_fault(unit_access_fault),
        .fault_hit(fault_hit)
    );

    // ==========================================================
    // Interrupt status and mask
    // ==========================================================
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic in_deep;

    wire deep_active = auto_clock_gating_select && (power_mode == DSG_MODE_DEEP);
    wire deep_entry = deep_active && !in_deep;
    wire [31:0] irq_events = {28'h0000000, deep_entry, fault_hit};
    wire [31:0] irq_clear = (wr_fire && wr_status) ? (w_data & strb_mask) : 32'h00000000;
    // A new event wins over a clear landing in the same cycle.
    wire [31:0] next_irq_status = ((irq_status & ~irq_clear) | irq_events) & IRQ_FIELD_MASK;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_deep <= 1'b0;
            irq_status <= 32'h00000000;
            irq_mask <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            in_deep <= deep_active;
            irq_status <= next_irq_status;
            if (wr_fire && wr_mask) begin
                irq_mask <= dsg_merge(irq_mask, w_data, strb_mask, IRQ_FIELD_MASK);
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    wire rd_fire = s_arvalid && s_arready;
    wire next_rvalid = rd_fire || (s_rvalid && !s_rready);
    wire rd_run = (s_araddr == ADDR_RUN_GATES);
    wire rd_sleep = (s_araddr == ADDR_SLEEP_GATES);
    wire rd_deep = (s_araddr == ADDR_DEEP_GATES);
    wire rd_config = (s_araddr == ADDR_RUN_CONFIG);
    wire rd_status = (s_araddr == ADDR_IRQ_STATUS);
    wire rd_mask = (s_araddr == ADDR_IRQ_MASK);
    wire rd_mapped = rd_run || rd_sleep || rd_deep || rd_config || rd_status || rd_mask;
    wire [31:0] rd_value = rd_run ? run_gates :
                           rd_sleep ? sleep_gates :
                           rd_deep ? deep_read :
                           rd_config ? run_config :
                           rd_status ? irq_status :
                           rd_mask ? irq_mask : 32'h00000000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_OKAY;
        end else begin
            s_arready <= !next_rvalid;
            s_rvalid <= next_rvalid;
            if (rd_fire) begin
                s_rdata <= rd_value;
                s_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    reset_gates_zero_a: assert property ($fell(reset) |->
        (deep_gates == GATE_RESET) && (unit_clock_enable == '0))
        else $error("unit gates not zero after reset");

    deep_read_reset_a: assert property (
        (rd_fire && rd_deep && (deep_gates == GATE_RESET)) |=> (s_rdata == DEEP_RESET))
        else $error("deep gate register does not read its reset value");

    reserved_bits_a: assert property (
        (rd_fire && rd_deep) |=> ((s_rdata & ~(GATE_WRITE_MASK | DEEP_FIXED_ONES)) == 0))
        else $error("reserved bits of deep gate register read nonzero");

    deep_write_map_a: assert property (
        (wr_fire && wr_deep && (w_strb == 4'hF))
        |=> (deep_gates == ($past(w_data) & GATE_WRITE_MASK)) && s_bvalid)
        else $error("deep gate write at its offset not stored");

    deep_mode_gates_a: assert property (
        (auto_clock_gating_select && (power_mode == DSG_MODE_DEEP))
        |=> (unit_clock_enable[UNIT_PWM] == $past(deep_gates[BIT_PWM]))
            && (unit_clock_enable[UNIT_ADC] == $past(deep_gates[BIT_ADC]))
            && (unit_clock_enable[UNIT_WATCHDOG] == $past(deep_gates[BIT_WATCHDOG])))
        else $error("deep-sleep enables not applied in deep-sleep");

    sleep_mode_gates_a: assert property (
        (auto_clock_gating_select && (power_mode == DSG_MODE_SLEEP))
        |=> (unit_clock_enable == $past(sleep_units)))
        else $error("sleep enables not applied in sleep");

    no_auto_run_a: assert property (
        (!auto_clock_gating_select && $stable(run_units))[*2]
        |-> (unit_clock_enable == run_units))
        else $error("run enables not used without auto gating");

    auto_select_a: assert property (
        (!auto_clock_gating_select && (deep_units != run_units))
        |=> (unit_clock_enable != $past(deep_units)))
        else $error("deep-sleep set used without auto gating");

    gated_fault_a: assert property (
        (unit_access_valid && (unit_access_unit < 2'(NUM_UNITS))
            && !unit_clock_enable[unit_access_unit])
        |=> (unit_access_done && unit_access_fault))
        else $error("access to gated unit not faulted");

    clocked_ok_a: assert property (
        (unit_access_valid && (unit_access_unit < 2'(NUM_UNITS))
            && unit_clock_enable[unit_access_unit])
        |=> (unit_access_done && !unit_access_fault))
        else $error("access to clocked unit faulted");

    irq_level_a: assert property (
        ((irq_status & irq_mask) != 0) |=> irq)
        else $error("unmasked status did not raise interrupt");

    run_mode_gates_a: assert property (
        (auto_clock_gating_select && (power_mode == DSG_MODE_RUN))
        |=> (unit_clock_enable == $past(run_units)))
        else $error("run enables not applied in run mode");

    // An unmapped read must still answer, or the master would hang on it.
    unmapped_read_a: assert property (
        (rd_fire && !rd_mapped)
        |=> (s_rvalid && (s_rresp == RESP_SLVERR) && (s_rdata == 32'h00000000)))
        else $error("unmapped read not refused");

endmodule : dsg_clock_gating

// file: bench/dsg_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Processor core side of the unit access port
// ==========================================================
module dsg_core_model (
    input wire logic clk,
    output logic unit_access_valid,
    output logic [1:0] unit_access_unit,
    input wire logic unit_access_done,
    input wire logic unit_access_fault
);
    initial begin
        unit_access_valid = 1'b0;
        unit_access_unit = 2'h0;
    end

    // One access, then the answer that stands for the single cycle after it.
    task automatic access(input logic [1:0] unit, output logic done, output logic fault);
        @(posedge clk);
        unit_access_valid <= 1'b1;
        unit_access_unit <= unit;
        @(posedge clk);
        unit_access_valid <= 1'b0;
        // The unit number is inverted once idle so a stale value never looks valid.
        unit_access_unit <= ~unit;
        #1;
        done = unit_access_done;
        fault = unit_access_fault;
    endtask : access
endmodule : dsg_core_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import dsg_pkg::*;
;
    logic clk, reset;
    logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, irq;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, power_mode, acc_unit;
    logic [NUM_UNITS-1:0] unit_clock_enable;
    logic acc_valid, acc_done, acc_fault;
    int fails = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [1:0] resp;
    logic done, fault;
    logic [2:0] exp_en;

    dsg_clock_gating dsg_clock_gating_inst (.clk(clk), .reset(reset),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .power_mode(power_mode), .unit_clock_enable(unit_clock_enable),
        .unit_access_valid(acc_valid), .unit_access_unit(acc_unit),
        .unit_access_done(acc_done), .unit_access_fault(acc_fault), .irq(irq));

    dsg_core_model dsg_core_model_inst (.clk(clk), .unit_access_valid(acc_valid),
        .unit_access_unit(acc_unit), .unit_access_done(acc_done),
        .unit_access_fault(acc_fault));

    // ==========================================================
    // Clock, watchdog and verdict
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // The tests need well under a thousand cycles; this allows ten times that.
    initial begin
        #(10000 * 4);
        fails++;
        conclude();
    end

    // ==========================================================
    // Register bus master and comparison
    // ==========================================================
    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        cmp_count++;
        if (exp !== act) begin
            fails++;
            $display("[FAIL] t=%0t expected %h got %h", $time, exp, act);
        end
    endtask : chk

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && s_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready === 1'b1) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        while (s_bvalid !== 1'b1) @(posedge clk);
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [31:0] a);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge clk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) @(posedge clk);
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
    endtask : bus_read

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        reset = 1'b1;
        {s_awaddr, s_wdata, s_araddr} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        s_wstrb = 4'h0;
        power_mode = 2'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;

        bus_read(ADDR_DEEP_GATES);
        chk(32'h00000040, rd);
        chk({30'h0, RESP_OKAY}, {30'h0, resp});
        bus_read(ADDR_RUN_GATES);
        chk(32'h00000000, rd);
        chk(32'h00000000, {29'h0, unit_clock_enable});
        $display("Reset values done");

        bus_write(ADDR_DEEP_GATES, 32'hFFFFFFFF);
        bus_read(ADDR_DEEP_GATES);
        chk(32'h00110048, rd);
        bus_write(ADDR_DEEP_GATES, 32'h00000000);
        bus_read(ADDR_DEEP_GATES);
        chk(32'h00000040, rd);
        bus_write(ADDR_DEEP_GATES, rd | 32'h00010000);
        bus_read(ADDR_DEEP_GATES);
        chk(32'h00010040, rd);
        bus_write(SYS_CTRL_BASE + 32'h00000124, 32'h00000008);
        chk({30'h0, RESP_SLVERR}, {30'h0, resp});
        bus_read(SYS_CTRL_BASE + 32'h00000124);
        chk({30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("Register access done");

        bus_write(ADDR_RUN_GATES, 32'h00000008);
        bus_write(ADDR_SLEEP_GATES, 32'h00010000);
        bus_write(ADDR_DEEP_GATES, 32'h00100000);
        for (int auto_on = 0; auto_on < 2; auto_on++) begin
            bus_write(ADDR_RUN_CONFIG, auto_on);
            for (int m = 0; m < 4; m++) begin
                @(posedge clk);
                power_mode <= 2'(m);
                repeat (3) @(posedge clk);
                exp_en = 3'b001;
                if (auto_on == 1 && m == 1) exp_en = 3'b010;
                if (auto_on == 1 && m == 2) exp_en = 3'b100;
                chk({29'h0, exp_en}, {29'h0, unit_clock_enable});
            end
        end
        $display("Mode selection done");

        @(posedge clk);
        power_mode <= 2'h2;
        repeat (3) @(posedge clk);
        for (int u = 0; u < 4; u++) begin
            dsg_core_model_inst.access(2'(u), done, fault);
            chk(32'h1, {31'h0, done});
            chk({31'h0, u != 2}, {31'h0, fault});
        end
        $display("Unit access done");

        bus_read(ADDR_IRQ_STATUS);
        chk(32'h0000000B, rd);
        bus_read(ADDR_IRQ_MASK);
        chk(32'h00000000, rd);
        chk(32'h0, {31'h0, irq});
        bus_write(ADDR_IRQ_MASK, 32'h00000001);
        repeat (2) @(posedge clk);
        chk(32'h1, {31'h0, irq});
        bus_write(ADDR_IRQ_STATUS, 32'h00000001);
        repeat (2) @(posedge clk);
        chk(32'h0, {31'h0, irq});
        bus_read(ADDR_IRQ_STATUS);
        chk(32'h0000000A, rd);
        $display("Interrupt done");
        conclude();
    end
endmodule : testbench
